// *** rtl/msr_top.sv ***
// Matrix scan sequencer with reset sequencing and channel calibration.
// Assumes an AXI4-Lite master, a measurement engine on clk_sys and an async reset pin.
// What this block does
// - Scan drive lines row by row over receivers
// - Eight drive, six receive, forty-eight channels
// - Disabled channels are skipped in scanning
// - Per-channel charge-transfer pulse count
// - Per-channel threshold decides detect state
// - No communication until 10 ms after power-on
// - Ready 10 to 15 ms after pin release
// - Software reset command, completes in 30 ms
// - Attention asserted when any reset finishes
// - Reset flag set after every reset
// - Host read after attention continues initialization
// - Six initialization scans before normal scanning
// - Calibrate after every reset and when a channel is enabled
// - Recalibrate after detect exceeds neg_recal_delay
// - Anti-touch three-quarters threshold recalibrates, no touches
// - Recalibrate command calibrates the channels
// - Message on calibration start and completion
// - Attention drops during read, returns if pending
// - Message is header plus four data bytes
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module msr_top #(
	parameter int POR_CYCLES  = msr_pkg::POR_CYC,
	parameter int PIN_CYCLES  = msr_pkg::PIN_WAIT_CYC,
	parameter int SOFT_CYCLES = msr_pkg::SOFT_CYC,
	parameter int GAP_CYCLES  = msr_pkg::MIN_GAP_CYC
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// Device pins
	input  wire logic        rst_pin_n,
	output logic             attn_n,
	// Measurement engine
	output logic             meas_start,
	output logic [2:0]       meas_drive,
	output logic [2:0]       meas_recv,
	output logic [7:0]       meas_pulses,
	input  wire logic        meas_done,
	input  wire logic [15:0] meas_value,
	// AXI4-Lite slave
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp
);
	import msr_pkg::*;

	function automatic logic [5:0] chan_of(input logic [2:0] d, input logic [2:0] r);
		chan_of = 6'(d) * 6'd6 + 6'(r);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
		end
	endfunction

	// ----------------------------------------------------------------
	// Reset pin synchroniser and reset sequencer
	// ----------------------------------------------------------------
	logic        pin_s1_r, pin_s2_r, pin_s3_r, pin_lvl_r;
	logic [15:0] pin_low_r;
	logic [23:0] tmr_r, tgt_r;
	msr_rs_type  rs_r;
	logic        core_clr, soft_cmd, ready;
	assign ready    = (rs_r == RS_READY);
	assign core_clr = reset | ~ready;

	always_ff @(posedge clk_sys) begin
		pin_s1_r <= rst_pin_n;
		pin_s2_r <= pin_s1_r;
		pin_s3_r <= pin_s2_r;
		if (reset) begin
			pin_lvl_r <= 1'b1;
		end else if (pin_s2_r == pin_s3_r) begin
			pin_lvl_r <= pin_s3_r;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rs_r      <= RS_WAIT;
			tgt_r     <= 24'(POR_CYCLES);
			tmr_r     <= 24'h000000;
			pin_low_r <= 16'h0000;
		end else begin
			pin_low_r <= pin_lvl_r ? 16'h0000 : (pin_low_r == 16'hffff ? pin_low_r : pin_low_r + 16'h0001);
			tmr_r     <= tmr_r + 24'h000001;
			if (rs_r != RS_HELD && pin_low_r >= 16'(PIN_MIN_CYC)) begin
				rs_r <= RS_HELD;
			end else case (rs_r)
				RS_HELD: begin
					tmr_r <= 24'h000000;
					if (pin_lvl_r) begin
						rs_r  <= RS_WAIT;
						tgt_r <= 24'(PIN_CYCLES);
					end
				end
				RS_WAIT: begin
					if (tmr_r >= tgt_r) begin
						rs_r <= RS_READY;
					end
				end
				RS_READY: begin
					tmr_r <= 24'h000000;
					if (soft_cmd) begin
						rs_r  <= RS_WAIT;
						tgt_r <= 24'(SOFT_CYCLES);
					end
				end
				default: rs_r <= RS_WAIT;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	logic        aw_r, w_r, bvalid_r, rvalid_r;
	logic [7:0]  awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0]  wstrb_r;
	logic [1:0]  bresp_r, rresp_r;
	logic        wr_go, rd_go, pop;
	logic [5:0]  sel_r;
	logic [7:0]  recal_dly_r;
	logic [7:0]  pulses_r [CHANNELS];
	logic [7:0]  thr_r    [CHANNELS];
	logic [15:0] ref_r    [CHANNELS];
	logic [7:0]  dcnt_r   [CHANNELS];
	logic [47:0] en_r, det_r, cal_r;
	logic [2:0]  msg_r;
	logic        rstflag_r, busy_r, init_go_r, init_done;
	logic [31:0] cfg_old, cfg_new, wr_ctrl;
	logic [7:0]  msg_hdr;
	logic [31:0] msg_dat, rd_word;
	logic        rd_hit;

	assign s_axi_awready = ~aw_r;
	assign s_axi_wready  = ~w_r;
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign wr_go   = aw_r & w_r & ~bvalid_r;
	assign rd_go   = s_axi_arvalid & ~rvalid_r;
	assign wr_ctrl = merge(32'h00000000, wdata_r, wstrb_r);
	assign cfg_old = {15'h0000, en_r[sel_r], thr_r[sel_r], pulses_r[sel_r]};
	assign cfg_new = merge(cfg_old, wdata_r, wstrb_r);
	assign soft_cmd = wr_go & (awaddr_r == OFS_CTRL) & wr_ctrl[CTRL_SOFTRST];
	assign pop = rd_go & ready & (s_axi_araddr == OFS_MSGDAT) & (|msg_r);
	assign msg_hdr = msg_r[0] ? HDR_RESET : msg_r[1] ? HDR_CALST : msg_r[2] ? HDR_CALDN : HDR_NONE;
	assign msg_dat = {24'h000000, 3'h0, init_done, busy_r, rstflag_r, ready, 1'b0};
	assign rd_hit  = (s_axi_araddr <= OFS_CHREF) & (s_axi_araddr[1:0] == 2'h0);
	assign rd_word = (s_axi_araddr == OFS_STATUS) ? msg_dat :
			(s_axi_araddr == OFS_MSGHDR) ? {24'h000000, msg_hdr} :
			(s_axi_araddr == OFS_MSGDAT) ? msg_dat :
			(s_axi_araddr == OFS_CHSEL)  ? {26'h0000000, sel_r} :
			(s_axi_araddr == OFS_CHCFG)  ? cfg_old :
			(s_axi_araddr == OFS_RECAL_DLY) ? {24'h000000, recal_dly_r} :
			(s_axi_araddr == OFS_DETLO)  ? det_r[31:0] :
			(s_axi_araddr == OFS_DETHI)  ? {16'h0000, det_r[47:32]} :
			(s_axi_araddr == OFS_CHREF)  ? {16'h0000, ref_r[sel_r]} : 32'h00000000;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			aw_r     <= 1'b0;
			w_r      <= 1'b0;
			bvalid_r <= 1'b0;
			rvalid_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r  <= 32'h00000000;
			wstrb_r  <= 4'h0;
			bresp_r  <= RESP_OKAY;
			rresp_r  <= RESP_OKAY;
			rdata_r  <= 32'h00000000;
		end else begin
			if (s_axi_awvalid & ~aw_r) begin
				aw_r     <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid & ~w_r) begin
				w_r     <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r  <= ~ready ? RESP_SLV : (awaddr_r > OFS_RECAL_DLY || awaddr_r[1:0] != 2'h0) ? RESP_DEC : RESP_OKAY;
			end else if (bvalid_r & s_axi_bready) begin
				bvalid_r <= 1'b0;
				aw_r     <= 1'b0;
				w_r      <= 1'b0;
			end
			if (rd_go) begin
				rvalid_r <= 1'b1;
				rdata_r  <= ready ? rd_word : 32'h00000000;
				rresp_r  <= ~ready ? RESP_SLV : rd_hit ? RESP_OKAY : RESP_DEC;
			end else if (rvalid_r & s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Channel configuration
	// ----------------------------------------------------------------
	logic wr_cfg, en_rise, recal_cmd;
	assign wr_cfg    = wr_go & ready & (awaddr_r == OFS_CHCFG);
	assign en_rise   = wr_cfg & cfg_new[CFG_EN] & ~en_r[sel_r];
	assign recal_cmd = wr_go & ready & (awaddr_r == OFS_CTRL) & wr_ctrl[CTRL_RECAL];
	logic [31:0] recal_dly_new;
	assign recal_dly_new = merge({24'h000000, recal_dly_r}, wdata_r, wstrb_r);

	always_ff @(posedge clk_sys) begin
		if (core_clr) begin
			sel_r <= 6'h00;
			recal_dly_r <= RST_RECAL_DLY;
			en_r  <= {CHANNELS{1'b1}};
			for (int i = 0; i < CHANNELS; i++) begin
				pulses_r[i] <= RST_PULSES;
				thr_r[i]    <= RST_THR;
			end
		end else if (wr_go) begin
			if (awaddr_r == OFS_CHSEL && wstrb_r[0] && wdata_r[5:0] < 6'(CHANNELS)) begin
				sel_r <= wdata_r[5:0];
			end
			if (awaddr_r == OFS_RECAL_DLY) begin
				recal_dly_r <= recal_dly_new[7:0];
			end
			if (wr_cfg) begin
				pulses_r[sel_r] <= cfg_new[7:0];
				thr_r[sel_r]    <= cfg_new[15:8];
				en_r[sel_r]     <= cfg_new[CFG_EN];
			end
		end
	end

	// ----------------------------------------------------------------
	// Scan sequencer
	// ----------------------------------------------------------------
	msr_sc_type  sc_r;
	logic [2:0]  drv_r, rcv_r, init_cnt_r;
	logic [7:0]  gap_r;
	logic        start_r, last, upd;
	logic [5:0]  ch;
	logic [16:0] tdelta, adelta;
	logic        touch, anti, alone, dly_hit;
	logic [47:0] cal_set, cal_clr, cal_nxt;

	assign ch         = chan_of(drv_r, rcv_r);
	assign last       = (drv_r == 3'(DRIVE_LINES - 1)) & (rcv_r == 3'(RECV_LINES - 1));
	assign init_done  = (init_cnt_r == 3'(INIT_SCANS));
	assign meas_start = start_r;
	assign meas_drive = drv_r;
	assign meas_recv  = rcv_r;
	assign meas_pulses = pulses_r[ch];
	assign upd     = (sc_r == SC_MEAS) & meas_done;
	assign tdelta  = {1'b0, ref_r[ch]} - {1'b0, meas_value};
	assign adelta  = {1'b0, meas_value} - {1'b0, ref_r[ch]};
	assign touch   = ~tdelta[16] & (tdelta[15:0] >= {8'h00, thr_r[ch]});
	assign anti    = ~adelta[16] & ({adelta[15:0], 2'h0} >= {8'h00, thr_r[ch], 2'h0} - {10'h000, thr_r[ch]});
	assign alone   = ((det_r & ~(48'h1 << ch)) == 48'h0);
	assign dly_hit = (recal_dly_r != 8'h00) & (dcnt_r[ch] >= recal_dly_r) & touch;
	assign cal_set = ({CHANNELS{recal_cmd}} & en_r) |
			({CHANNELS{en_rise}} & (48'h1 << sel_r)) |
			({CHANNELS{upd & ~cal_r[ch] & init_done & (dly_hit | (anti & alone))}} & (48'h1 << ch));
	assign cal_clr = {CHANNELS{upd & cal_r[ch]}} & (48'h1 << ch);
	assign cal_nxt = (cal_r & ~cal_clr) | cal_set;

	always_ff @(posedge clk_sys) begin
		if (core_clr) begin
			sc_r       <= SC_IDLE;
			drv_r      <= 3'h0;
			rcv_r      <= 3'h0;
			init_cnt_r <= 3'h0;
			gap_r      <= 8'h00;
			start_r    <= 1'b0;
			det_r      <= 48'h0;
			cal_r      <= {CHANNELS{1'b1}};
			for (int i = 0; i < CHANNELS; i++) begin
				ref_r[i]  <= 16'h0000;
				dcnt_r[i] <= 8'h00;
			end
		end else begin
			start_r <= 1'b0;
			cal_r   <= cal_nxt;
			case (sc_r)
				SC_IDLE: begin
					if (init_go_r) begin
						sc_r <= SC_PICK;
					end
				end
				SC_PICK: begin
					if (en_r[ch]) begin
						start_r <= 1'b1;
						sc_r    <= SC_MEAS;
					end else if (last) begin
						sc_r  <= SC_GAP;
						gap_r <= 8'h00;
					end else begin
						rcv_r <= (rcv_r == 3'(RECV_LINES - 1)) ? 3'h0 : rcv_r + 3'h1;
						drv_r <= (rcv_r == 3'(RECV_LINES - 1)) ? drv_r + 3'h1 : drv_r;
					end
				end
				SC_MEAS: begin
					if (meas_done) begin
						if (cal_r[ch]) begin
							ref_r[ch]  <= meas_value;
							det_r[ch]  <= 1'b0;
							dcnt_r[ch] <= 8'h00;
						end else if (init_done) begin
							det_r[ch]  <= touch;
							dcnt_r[ch] <= (touch && dcnt_r[ch] != 8'hff) ? dcnt_r[ch] + 8'h01 : (touch ? dcnt_r[ch] : 8'h00);
						end
						if (last) begin
							sc_r  <= SC_GAP;
							gap_r <= 8'h00;
						end else begin
							sc_r  <= SC_PICK;
							rcv_r <= (rcv_r == 3'(RECV_LINES - 1)) ? 3'h0 : rcv_r + 3'h1;
							drv_r <= (rcv_r == 3'(RECV_LINES - 1)) ? drv_r + 3'h1 : drv_r;
						end
					end
				end
				SC_GAP: begin
					gap_r <= gap_r + 8'h01;
					if (gap_r >= 8'(GAP_CYCLES - 1)) begin
						sc_r  <= SC_PICK;
						drv_r <= 3'h0;
						rcv_r <= 3'h0;
						if (!init_done) begin
							init_cnt_r <= init_cnt_r + 3'h1;
						end
					end
				end
				default: sc_r <= SC_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Messages, status and attention
	// ----------------------------------------------------------------
	logic [2:0] msg_set, msg_pop, msg_nxt;
	logic       attn_n_r;
	assign msg_set = {busy_r & ~(|cal_r), ~busy_r & (|cal_r), 1'b0};
	assign msg_pop = !pop ? 3'h0 : msg_r[0] ? 3'h1 : msg_r[1] ? 3'h2 : 3'h4;
	assign msg_nxt = (msg_r & ~msg_pop) | msg_set;
	assign attn_n  = attn_n_r;

	always_ff @(posedge clk_sys) begin
		if (core_clr) begin
			msg_r     <= 3'h1;
			rstflag_r <= 1'b1;
			busy_r    <= 1'b0;
			init_go_r <= 1'b0;
			attn_n_r  <= 1'b1;
		end else begin
			msg_r    <= msg_nxt;
			busy_r   <= |cal_r;
			attn_n_r <= pop | ~(|msg_nxt);
			if (pop && msg_r[0]) begin
				init_go_r <= 1'b1;
			end
			if (wr_go && awaddr_r == OFS_STATUS && wr_ctrl[ST_RSTFLAG]) begin
				rstflag_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic [5:0] prev_ch_r;
	logic       fresh_r;

	// Remembers the last started channel; a new pass starts fresh.
	always_ff @(posedge clk_sys) begin
		if (core_clr || sc_r == SC_GAP) begin
			fresh_r <= 1'b1;
		end else if (start_r) begin
			fresh_r <= 1'b0;
		end
		if (start_r) begin
			prev_ch_r <= ch;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	scan_range_a: assert property (meas_start |-> meas_recv < 3'(RECV_LINES) && ch < 6'(CHANNELS))
		else $error("scan index out of matrix");
	skip_off_a: assert property (meas_start |-> $past(en_r[ch]))
		else $error("disabled channel measured");
	row_order_a: assert property (meas_start && !fresh_r |-> ch > prev_ch_r)
		else $error("scan order broken");
	busy_resp_a: assert property (wr_go && !ready |=> s_axi_bresp == RESP_SLV)
		else $error("write accepted before ready");
	attn_ready_a: assert property ($rose(ready) |=> !attn_n)
		else $error("attention not raised after reset");
	reset_flag_a: assert property ($rose(ready) |-> rstflag_r && msg_r[0])
		else $error("reset flag missing");
	init_quiet_a: assert property (!init_done |-> det_r == 48'h0)
		else $error("detect before initialization scans");
	base_capture_a: assert property (upd && cal_r[ch] && !core_clr |=> ref_r[$past(ch)] == $past(meas_value))
		else $error("baseline not captured");
	read_drop_a: assert property (pop |=> attn_n)
		else $error("attention held during read");
	cal_msg_a: assert property ($rose(busy_r) |-> msg_r[1])
		else $error("calibration start message missing");
endmodule

// *** rtl/msr_pkg.sv ***
// Constants shared by the matrix scan, reset and calibration controller.
// Assumes a 25 MHz system clock and a 32-bit AXI4-Lite register bus.
package msr_pkg;
	// ----------------------------------------------------------------
	// Matrix geometry
	// ----------------------------------------------------------------
	localparam int DRIVE_LINES = 8;
	localparam int RECV_LINES  = 6;
	localparam int CHANNELS    = 48;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ      = 25_000_000;
	localparam int POR_MS      = 10;
	localparam int PIN_WAIT_MS = 12;
	localparam int SOFT_MS     = 30;
	localparam int PIN_MIN_US  = 10;
	localparam int POR_CYC     = POR_MS * (CLK_HZ / 1000);
	localparam int PIN_WAIT_CYC = PIN_WAIT_MS * (CLK_HZ / 1000);
	localparam int SOFT_CYC    = SOFT_MS * (CLK_HZ / 1000);
	localparam int PIN_MIN_CYC = (PIN_MIN_US * (CLK_HZ / 1000) + 999) / 1000;
	localparam int INIT_SCANS  = 6;
	localparam int MIN_GAP_CYC = 16;
	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MSGHDR = 8'h08;
	localparam logic [7:0] OFS_MSGDAT = 8'h0c;
	localparam logic [7:0] OFS_CHSEL  = 8'h10;
	localparam logic [7:0] OFS_CHCFG  = 8'h14;
	localparam logic [7:0] OFS_RECAL_DLY = 8'h18;
	localparam logic [7:0] OFS_DETLO  = 8'h1c;
	localparam logic [7:0] OFS_DETHI  = 8'h20;
	localparam logic [7:0] OFS_CHREF  = 8'h24;
	// ----------------------------------------------------------------
	// Fields, message headers and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_SOFTRST = 0;
	localparam int CTRL_RECAL   = 1;
	localparam int ST_RSTFLAG   = 1;
	localparam int CFG_EN       = 16;
	localparam logic [7:0]  HDR_RESET  = 8'h01;
	localparam logic [7:0]  HDR_CALST  = 8'h02;
	localparam logic [7:0]  HDR_CALDN  = 8'h03;
	localparam logic [7:0]  HDR_NONE   = 8'hff;
	localparam logic [7:0]  RST_PULSES = 8'h10;
	localparam logic [7:0]  RST_THR    = 8'h14;
	localparam logic [7:0]  RST_RECAL_DLY = 8'h00;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLV   = 2'h2;
	localparam logic [1:0]  RESP_DEC   = 2'h3;
	typedef enum logic [1:0] {RS_WAIT, RS_HELD, RS_READY} msr_rs_type;
	typedef enum logic [1:0] {SC_IDLE, SC_PICK, SC_MEAS, SC_GAP} msr_sc_type;
endpackage

// *** tb/msr_meas_model.sv ***
// Measurement engine model facing the matrix scan controller.
// Assumes one measurement at a time, started by a one-cycle meas_start on clk_sys.
`timescale 1ns/1ps
module msr_meas_model (
	// Clock
	input  wire logic        clk_sys,
	// Scan requests
	input  wire logic        meas_start,
	input  wire logic [2:0]  meas_drive,
	input  wire logic [2:0]  meas_recv,
	input  wire logic [7:0]  meas_pulses,
	// Results
	output logic             meas_done,
	output logic [15:0]      meas_value
);
	logic [15:0] val [48];
	logic [13:0] log_q [$];
	int          passes = 0;
	int          last   = 99;
	int          wait_n = 0;
	int          ch     = 0;

	initial begin
		for (int i = 0; i < 48; i++) val[i] = 16'h0800 + 16'(i * 3);
	end

	// Answers each request after a random latency; the value line shows the inverse when idle.
	always @(posedge clk_sys) begin
		meas_done  <= (wait_n == 1);
		meas_value <= (wait_n == 1) ? val[ch] : ~val[ch];
		if (meas_start) begin
			ch = meas_drive * 6 + meas_recv;
			if (ch <= last) passes <= passes + 1;
			last = ch;
			log_q.push_back({meas_pulses, meas_drive, meas_recv});
			wait_n <= 1 + $urandom_range(3);
		end else if (wait_n > 0) begin
			wait_n <= wait_n - 1;
		end
	end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the matrix scan, reset and calibration controller.
// Assumes the measurement engine model and shortened reset waits.
`timescale 1ns/1ps
module tb_top;
	import msr_pkg::*;
	localparam int POR = 200, PIN = 300, SOFT = 400;
	logic        clk_sys = 1'b0, reset = 1'b1, rst_pin_n = 1'b1;
	logic        attn_n, meas_start, meas_done;
	logic [2:0]  meas_drive, meas_recv;
	logic [7:0]  meas_pulses;
	logic [15:0] meas_value, base_v;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        en [48];
	logic [7:0]  pul [48];
	int          fail_count = 0, check_count = 0, cyc = 0, t0 = 0;

	msr_top #(.POR_CYCLES(POR), .PIN_CYCLES(PIN), .SOFT_CYCLES(SOFT), .GAP_CYCLES(16)) dut_u (
		.clk_sys, .reset, .rst_pin_n, .attn_n, .meas_start, .meas_drive, .meas_recv, .meas_pulses,
		.meas_done, .meas_value, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
		.s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
		.s_axi_rresp);
	msr_meas_model mdl_u (.clk_sys, .meas_start, .meas_drive, .meas_recv, .meas_pulses, .meas_done,
		.meas_value);

	// ----------------------------------------------------------------
	// Clock, cycle count, checking and bus tasks
	// ----------------------------------------------------------------
	initial forever #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task finish_test;
		$display("checks %0d failures %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic wait_pass(input int n);
		int p;
		p = mdl_u.passes;
		wait (mdl_u.passes >= p + n);
	endtask

	// Reads every pending message; headers are packed oldest first.
	task automatic drain(input logic [31:0] e);
		logic [31:0] m;
		m = 32'h0;
		repeat (2) @(posedge clk_sys);
		while (attn_n === 1'b0) begin
			rd(OFS_MSGHDR);
			m = {m[23:0], d[7:0]};
			rd(OFS_MSGDAT);
			chk("attn_pop", attn_n, 1'b1);
			repeat (2) @(posedge clk_sys);
		end
		chk("msgs", m, e);
	endtask

	task automatic cfg(input int c);
		wr(OFS_CHSEL, 32'(c));
		wr(OFS_CHCFG, {15'h0, en[c], RST_THR, pul[c]});
	endtask

	task automatic det_chk(input int k, input logic e);
		logic [31:0] lo;
		rd(OFS_DETLO);
		lo = d;
		rd(OFS_DETHI);
		chk("detect", (k < 32) ? lo[k] : d[k - 32], e);
	endtask

	task automatic ref_chk(input int k, input logic [15:0] e);
		wr(OFS_CHSEL, 32'(k));
		rd(OFS_CHREF);
		chk("baseline", d[15:0], e);
	endtask

	// Each logged request must be the next enabled channel in row order.
	task automatic scan_chk;
		int c, nx;
		wait_pass(2);
		mdl_u.log_q.delete();
		wait_pass(2);
		for (int i = 1; i < mdl_u.log_q.size(); i++) begin
			c = mdl_u.log_q[i - 1][5:3] * 6 + mdl_u.log_q[i - 1][2:0];
			nx = (c + 1) % 48;
			while (!en[nx]) nx = (nx + 1) % 48;
			chk("scan", mdl_u.log_q[i], {pul[nx], 3'(nx / 6), 3'(nx % 6)});
		end
	endtask

	task automatic after_rst(input int n);
		rd(OFS_STATUS);
		chk("early_resp", r, RESP_SLV);
		wait (cyc == t0 + n - 2);
		chk("attn_early", attn_n, 1'b1);
		wait (cyc == t0 + n + 4);
		chk("attn_ready", attn_n, 1'b0);
		rd(OFS_STATUS);
		chk("rst_flag", d[2:1], 2'b11);
		rd(OFS_MSGHDR);
		chk("hdr_reset", d[7:0], HDR_RESET);
		rd(OFS_MSGDAT);
		chk("msg_data", d[4:1], 4'b0111);
		chk("attn_pop", attn_n, 1'b1);
		for (int i = 0; i < 48; i++) begin
			en[i] = 1'b1;
			pul[i] = RST_PULSES;
		end
		rd(OFS_CHCFG);
		chk("cfg_reset", d, {15'h0, 1'b1, RST_THR, RST_PULSES});
		wait_pass(8);
		rd(OFS_STATUS);
		chk("init_scans", d[4:3], 2'b10);
		drain(32'h0203);
	endtask

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (80000) @(posedge clk_sys);
		fail_count++;
		finish_test;
	end

	initial begin
		int c, c0, k;
		void'($urandom(58390));
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		t0 = cyc;
		after_rst(POR);
		rd(8'h30);
		chk("unmapped", r, RESP_DEC);
		wr(OFS_CHREF, 32'h0);
		chk("ro_write", r, RESP_DEC);
		wr(OFS_STATUS, 32'h2);
		rd(OFS_STATUS);
		chk("flag_clear", d[2], 1'b0);
		for (int i = 0; i < 8; i++) begin
			c = i * 6 + $urandom_range(5);
			if (i == 0) c0 = c;
			en[c] = i[0];
			pul[c] = 8'($urandom_range(255, 1));
			cfg(c);
		end
		scan_chk();
		drain(32'h0);
		en[c0] = 1'b1;
		cfg(c0);
		scan_chk();
		drain(32'h0203);
		do k = $urandom_range(47); while (!en[k]);
		base_v = mdl_u.val[k];
		ref_chk(k, base_v);
		mdl_u.val[k] = base_v - 16'd19;
		wait_pass(2);
		det_chk(k, 1'b0);
		mdl_u.val[k] = base_v - 16'd20;
		wait_pass(2);
		det_chk(k, 1'b1);
		wr(OFS_RECAL_DLY, 32'h3);
		wait_pass(6);
		ref_chk(k, base_v - 16'd20);
		drain(32'h0203);
		mdl_u.val[k] = base_v - 16'd5;
		wait_pass(3);
		ref_chk(k, base_v - 16'd5);
		drain(32'h0203);
		mdl_u.val[k] = base_v - 16'd3;
		wr(OFS_CTRL, 32'h2);
		wait_pass(3);
		ref_chk(k, base_v - 16'd3);
		drain(32'h0203);
		wr(OFS_CTRL, 32'h1);
		t0 = cyc;
		after_rst(SOFT);
		rst_pin_n <= 1'b0;
		repeat (100) @(posedge clk_sys);
		rst_pin_n <= 1'b1;
		repeat (10) @(posedge clk_sys);
		rd(OFS_STATUS);
		chk("short_pin", r, RESP_OKAY);
		rst_pin_n <= 1'b0;
		repeat (300) @(posedge clk_sys);
		rst_pin_n <= 1'b1;
		t0 = cyc;
		after_rst(PIN + 5);
		finish_test;
	end
endmodule
